// ==== rtl/arith_core.sv ====
// Arithmetic core with register pages and status flags behind APB
// Function
// - Carry reads 1 on a carry out of an addition or no borrow in a subtraction, else 0.
// - Destination bit 0 sends the result to the work register, 1 back to the register.
// - Register-page operands address registers 0x00 to 0x3F through a 6-bit field.
// - F-page operands are only legal from 0x5 to 0xF.
// - S-page operands run from 0x0 to 0xF through a 4-bit field.
// - Immediates are 8 bits and a bit operand picks one of bits 0 to 7.
// - The power-down flag is 1 after power-up or a watchdog kick and 0 after halt.
// - The timeout flag is 1 after power-up, kick or halt and 0 on a watchdog timeout.
// - Add register with carry sums register, work and carry, updates Z, DC, C in one cycle.
// - Add register sums work and register without carry, updates Z, DC, C in one cycle.
// - Add immediate with carry puts work plus immediate plus carry in work in one cycle.
// - Add immediate puts work plus immediate in work, ignoring carry, in one cycle.
// - AND register ands work with the register, touches only Z, in one cycle.
// - Clear bit zeroes the chosen bit of the register, no flags change, in one cycle.
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module arith_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [arith_core_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wdt_timeout,
  output logic powerdown_flag_n,
  output logic timeout_flag_n
);
  import arith_core_pkg::*;

  typedef struct packed {
    logic [REG_COUNT-1:0][DATA_W-1:0] rregs;
    logic [SPR_COUNT-1:0][DATA_W-1:0] fregs;
    logic [SPR_COUNT-1:0][DATA_W-1:0] sregs;
    logic [DATA_W-1:0] work;
    logic carry;
    logic nibble_carry_flag;
    logic zero;
    logic pd_n;
    logic to_n;
    logic err;
    logic rdy;
    logic slverr;
    logic [31:0] rdata;
  } state_t;

  state_t st_q;
  state_t st_d;
  alu_if alu ();

  // Decoding of a bus address, shared by read and write paths
  function automatic kind_t addr_kind(input logic [ADDR_W-1:0] a);
    logic [3:0] region;
    logic [SPR_AW-1:0] sidx;
    logic hi_zero;
    region = a[ADDR_W-1:REGION_LSB];
    sidx = a[WIDX_LSB +: SPR_AW];
    hi_zero = (a[WIDX_LSB+SPR_AW +: 2] == 2'b00);
    addr_kind = kind_none;
    if (a[WIDX_LSB-1:0] != 2'b00) begin
      addr_kind = kind_none;
    end else if (a == OFF_CMD) begin
      addr_kind = kind_cmd;
    end else if (a == OFF_WORK) begin
      addr_kind = kind_work;
    end else if (a == OFF_STATUS) begin
      addr_kind = kind_status;
    end else if (region == REGION_R) begin
      addr_kind = kind_rreg;
    end else if (region == REGION_F && hi_zero && sidx >= F_MIN && sidx <= F_MAX) begin
      addr_kind = kind_freg;
    end else if (region == REGION_S && hi_zero && sidx <= S_MAX) begin
      addr_kind = kind_sreg;
    end
  endfunction : addr_kind

  // Legal register operand of a command
  function automatic logic operand_ok(input page_t p, input logic [REG_AW-1:0] a);
    operand_ok = 1'b0;
    case (p)
      page_r: operand_ok = (a <= R_MAX);
      page_f: operand_ok = (a[REG_AW-1:SPR_AW] == 2'b00) && (a[SPR_AW-1:0] >= F_MIN);
      page_s: operand_ok = (a[REG_AW-1:SPR_AW] == 2'b00) && (a[SPR_AW-1:0] <= S_MAX);
      default: operand_ok = 1'b0;
    endcase
  endfunction : operand_ok

  function automatic logic [DATA_W-1:0] read_operand(input state_t s, input page_t p,
                                                     input logic [REG_AW-1:0] a);
    read_operand = '0;
    case (p)
      page_r: read_operand = s.rregs[a];
      page_f: read_operand = s.fregs[a[SPR_AW-1:0]];
      page_s: read_operand = s.sregs[a[SPR_AW-1:0]];
      default: read_operand = '0;
    endcase
  endfunction : read_operand

  function automatic logic [31:0] read_word(input state_t s, input logic [ADDR_W-1:0] a);
    logic [REG_AW-1:0] widx;
    widx = a[WIDX_LSB +: REG_AW];
    read_word = '0;
    case (addr_kind(a))
      kind_work: read_word[DATA_W-1:0] = s.work;
      kind_status: begin
        read_word[ST_C] = s.carry;
        read_word[ST_DC] = s.nibble_carry_flag;
        read_word[ST_Z] = s.zero;
        read_word[ST_PD] = s.pd_n;
        read_word[ST_TO] = s.to_n;
        read_word[ST_ERR] = s.err;
      end
      kind_rreg: read_word[DATA_W-1:0] = s.rregs[widx];
      kind_freg: read_word[DATA_W-1:0] = s.fregs[widx[SPR_AW-1:0]];
      kind_sreg: read_word[DATA_W-1:0] = s.sregs[widx[SPR_AW-1:0]];
      default: read_word = '0;
    endcase
  endfunction : read_word

  // Command fields as seen on the bus during the taking edge
  op_t cmd_op;
  page_t cmd_page;
  logic cmd_dest;
  logic [BIT_AW-1:0] cmd_bit;
  logic [DATA_W-1:0] cmd_imm;
  logic [REG_AW-1:0] cmd_reg;
  logic [DATA_W-1:0] cmd_operand;
  logic take;

  assign cmd_op = op_t'(pwdata[CMD_OP_LSB +: 4]);
  assign cmd_page = page_t'(pwdata[CMD_PAGE_LSB +: 2]);
  assign cmd_dest = pwdata[CMD_DEST_POS];
  assign cmd_bit = pwdata[CMD_BIT_LSB +: BIT_AW];
  assign cmd_imm = pwdata[CMD_IMM_LSB +: DATA_W];
  assign cmd_reg = pwdata[CMD_REG_LSB +: REG_AW];
  assign cmd_operand = read_operand(st_q, cmd_page, cmd_reg);
  assign take = psel && penable && st_q.rdy;

  // Immediate forms feed the immediate, carry only on the with-carry forms
  assign alu.a = st_q.work;
  assign alu.b = (cmd_op == add_imm_with_carry || cmd_op == add_imm_op) ? cmd_imm : cmd_operand;
  assign alu.cin = (cmd_op == add_reg_with_carry || cmd_op == add_imm_with_carry) ?
                   st_q.carry : 1'b0;

  nibble_adder u_adder (
    .port(alu)
  );

  always_comb begin
    logic [DATA_W-1:0] result;
    logic wb_en;
    logic [REG_AW-1:0] widx;
    result = '0;
    wb_en = 1'b0;
    widx = paddr[WIDX_LSB +: REG_AW];
    st_d = st_q;
    st_d.rdy = 1'b0;
    st_d.slverr = 1'b0;
    // One wait state: answer and read data are registered together
    if (psel && penable && !st_q.rdy) begin
      st_d.rdy = 1'b1;
      st_d.slverr = (addr_kind(paddr) == kind_none);
      st_d.rdata = pwrite ? 32'h0000_0000 : read_word(st_q, paddr);
    end
    if (take && pwrite && !st_q.slverr) begin
      case (addr_kind(paddr))
        kind_work: st_d.work = pwdata[DATA_W-1:0];
        kind_status: begin
          st_d.carry = pwdata[ST_C];
          st_d.nibble_carry_flag = pwdata[ST_DC];
          st_d.zero = pwdata[ST_Z];
          if (pwdata[ST_ERR]) begin
            st_d.err = 1'b0;
          end
        end
        kind_rreg: st_d.rregs[widx] = pwdata[DATA_W-1:0];
        kind_freg: st_d.fregs[widx[SPR_AW-1:0]] = pwdata[DATA_W-1:0];
        kind_sreg: st_d.sregs[widx[SPR_AW-1:0]] = pwdata[DATA_W-1:0];
        kind_cmd: begin
          case (cmd_op)
            add_reg_with_carry, add_reg_op, and_reg_op: begin
              if (!operand_ok(cmd_page, cmd_reg)) begin
                st_d.err = 1'b1;
              end else begin
                if (cmd_op == and_reg_op) begin
                  result = st_q.work & cmd_operand;
                end else begin
                  result = alu.sum;
                  st_d.carry = alu.cout;
                  st_d.nibble_carry_flag = alu.ncarry;
                end
                st_d.zero = (result == '0);
                if (cmd_dest == DEST_WORK) begin
                  st_d.work = result;
                end else begin
                  wb_en = 1'b1;
                end
              end
            end
            add_imm_with_carry, add_imm_op: begin
              st_d.work = alu.sum;
              st_d.carry = alu.cout;
              st_d.nibble_carry_flag = alu.ncarry;
              st_d.zero = (alu.sum == '0);
            end
            clear_reg_bit_op: begin
              if (!operand_ok(cmd_page, cmd_reg)) begin
                st_d.err = 1'b1;
              end else begin
                result = cmd_operand;
                result[cmd_bit] = 1'b0;
                wb_en = 1'b1;
              end
            end
            watchdog_kick_op: begin
              st_d.pd_n = 1'b1;
              st_d.to_n = 1'b1;
            end
            halt_op: begin
              st_d.pd_n = 1'b0;
              st_d.to_n = 1'b1;
            end
            op_nop: begin
            end
            default: st_d.err = 1'b1;
          endcase
        end
        default: begin
        end
      endcase
    end
    if (wb_en) begin
      case (cmd_page)
        page_r: st_d.rregs[cmd_reg] = result;
        page_f: st_d.fregs[cmd_reg[SPR_AW-1:0]] = result;
        page_s: st_d.sregs[cmd_reg[SPR_AW-1:0]] = result;
        default: begin
        end
      endcase
    end
    // Timeout beats a kick or halt in the same cycle so it is never lost
    if (wdt_timeout) begin
      st_d.to_n = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
      st_q.work <= WORK_RST;
      st_q.pd_n <= 1'b1;
      st_q.to_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.rdy;
  assign pslverr = st_q.slverr;
  assign powerdown_flag_n = st_q.pd_n;
  assign timeout_flag_n = st_q.to_n;
endmodule : arith_core

// ==== rtl/arith_core_pkg.sv ====
// Constants, register map and types for the arithmetic core
package arith_core_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned REG_AW = 6;
  localparam int unsigned SPR_AW = 4;
  localparam int unsigned BIT_AW = 3;
  localparam int unsigned REG_COUNT = 64;
  localparam int unsigned SPR_COUNT = 16;

  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] OFF_CMD = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_WORK = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h008;
  localparam logic [3:0] REGION_R = 4'h1;
  localparam logic [3:0] REGION_F = 4'h2;
  localparam logic [3:0] REGION_S = 4'h3;
  localparam int unsigned REGION_LSB = 8;
  localparam int unsigned WIDX_LSB = 2;

  // Command word fields
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_DEST_POS = 4;
  localparam int unsigned CMD_BIT_LSB = 5;
  localparam int unsigned CMD_IMM_LSB = 8;
  localparam int unsigned CMD_REG_LSB = 16;
  localparam int unsigned CMD_PAGE_LSB = 22;

  // Status word fields
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_PD = 3;
  localparam int unsigned ST_TO = 4;
  localparam int unsigned ST_ERR = 5;

  // Operand ranges
  localparam logic [SPR_AW-1:0] F_MIN = 4'h5;
  localparam logic [SPR_AW-1:0] F_MAX = 4'hF;
  localparam logic [SPR_AW-1:0] S_MAX = 4'hF;
  localparam logic [REG_AW-1:0] R_MAX = 6'h3F;

  localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
  localparam logic DEST_WORK = 1'b0;

  typedef enum logic [3:0] {
    op_nop,
    add_reg_with_carry,
    add_reg_op,
    add_imm_with_carry,
    add_imm_op,
    and_reg_op,
    clear_reg_bit_op,
    watchdog_kick_op,
    halt_op
  } op_t;

  typedef enum logic [1:0] {
    page_r,
    page_f,
    page_s
  } page_t;

  typedef enum logic [2:0] {
    kind_none,
    kind_cmd,
    kind_work,
    kind_status,
    kind_rreg,
    kind_freg,
    kind_sreg
  } kind_t;
endpackage : arith_core_pkg

// ==== rtl/alu_if.sv ====
// Adder operands and results between the core and its adder
`timescale 1ns/1ns
interface alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic [7:0] sum;
  logic cout;
  logic ncarry;
  modport core (output a, output b, output cin, input sum, input cout, input ncarry);
  modport adder (input a, input b, input cin, output sum, output cout, output ncarry);
endinterface : alu_if

// ==== rtl/nibble_adder.sv ====
// Eight-bit adder split at the nibble so the half carry is visible
`timescale 1ns/1ns
module nibble_adder (
  alu_if.adder port
);
  import arith_core_pkg::*;
  logic [4:0] lo;
  logic [4:0] hi;

  assign lo = {1'b0, port.a[3:0]} + {1'b0, port.b[3:0]} + {4'h0, port.cin};
  assign hi = {1'b0, port.a[7:4]} + {1'b0, port.b[7:4]} + {4'h0, lo[4]};
  assign port.sum = {hi[3:0], lo[3:0]};
  assign port.ncarry = lo[4];
  assign port.cout = hi[4];
endmodule : nibble_adder

// ==== verification/arith_core_properties.sv ====
// Port-level assertions for the arithmetic core
`timescale 1ns/1ns
module arith_core_properties
  import arith_core_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [arith_core_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wdt_timeout,
  input wire logic powerdown_flag_n,
  input wire logic timeout_flag_n
);
  logic cmd_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Command write completing, timeout absent so it cannot win
  sequence cmd_s(logic [3:0] op);
    psel && penable && pready && pwrite && paddr == OFF_CMD && pwdata[3:0] == op
      && !wdt_timeout;
  endsequence
  always_ff @(posedge mclk) begin
    cmd_q <= psel && penable && pready && pwrite && paddr == OFF_CMD;
  end
  AST_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  AST_ONE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_RPAGE: assert property (pready && paddr[11:8] == REGION_R && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("R page refused");
  AST_FLOW: assert property (pready && paddr[11:8] == REGION_F && paddr[7:2] < 6'h05
    |-> pslverr) else $error("low F page taken");
  AST_SPAGE: assert property (pready && paddr[11:8] == REGION_S && paddr[7:6] == 2'h0
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("S page refused");
  AST_HALT: assert property (cmd_s(4'h8) |=> !powerdown_flag_n && timeout_flag_n)
    else $error("halt flags");
  AST_KICK: assert property (cmd_s(4'h7) |=> powerdown_flag_n && timeout_flag_n)
    else $error("kick flags");
  AST_TOUT: assert property (wdt_timeout |=> !timeout_flag_n)
    else $error("timeout missed");
  AST_TFALL: assert property ($fell(timeout_flag_n) |-> $past(wdt_timeout))
    else $error("timeout without cause");
  AST_PDCHG: assert property (!$past(rst) && $changed(powerdown_flag_n) |-> cmd_q)
    else $error("pd flag moved alone");
endmodule : arith_core_properties

// ==== verification/tb.sv ====
// Self-checking bench for the arithmetic core
`timescale 1ns/1ns
module tb;
  import arith_core_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic wdt_timeout = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic powerdown_flag_n;
  logic timeout_flag_n;
  logic [31:0] rd;
  logic er;
  logic [15:0] lf = 16'h0026;
  int n_fail = 0;
  int checked = 0;
  int op, dst, bi, im, ri, r, a, b, s, res, st, cy, dc, z;
  logic [11:0] pa[6] = '{12'h210, 12'h214, 12'h23C, 12'h300, 12'h33C, 12'h101};
  logic pe[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  arith_core i_arith_core (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdt_timeout(wdt_timeout), .powerdown_flag_n(powerdown_flag_n),
    .timeout_flag_n(timeout_flag_n));
  initial begin
    forever #4 mclk = ~mclk;
  end
  function automatic int rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return int'(lf);
  endfunction : rnd
  task automatic final_report();
    $display("counts: %0d checked, %0d failed", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Request held until pready is seen high at a rising edge; answer taken at that edge
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      final_report();
    end
  endtask : apb
  // Event 0 pulses the watchdog, else a command; then pd/to read back
  task automatic flag_step(input int ev, input logic [1:0] e);
    if (ev == 0) begin
      @(posedge mclk);
      wdt_timeout <= 1'b1;
      @(posedge mclk);
      wdt_timeout <= 1'b0;
    end else begin
      apb(1'b1, OFF_CMD, ev);
    end
    apb(1'b0, OFF_STATUS, 0);
    chk("pd_to", e, rd[4:3]);
    chk("flag_pins", e, {timeout_flag_n, powerdown_flag_n});
  endtask : flag_step
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, OFF_STATUS, 0);
    chk("status", 32'h18, rd);
    $display("test reset done");
    for (int k = 0; k < 90; k++) begin
      op = 1 + k % 6;
      ri = rnd() % 64;
      r = rnd() % 256;
      a = rnd() % 256;
      st = rnd() % 8;
      im = rnd() % 256;
      dst = rnd() % 2;
      bi = rnd() % 8;
      apb(1'b1, {REGION_R, ri[5:0], 2'h0}, r);
      apb(1'b1, OFF_WORK, a);
      apb(1'b1, OFF_STATUS, st);
      apb(1'b1, OFF_CMD, op | (dst << 4) | (bi << 5) | (im << 8) | (ri << 16));
      cy = st & 1;
      dc = (st >> 1) & 1;
      z = (st >> 2) & 1;
      s = (op == 1 || op == 3) ? cy : 0;
      b = (op < 3) ? r : im;
      if (op <= 4) begin
        res = (a + b + s) & 255;
        cy = (a + b + s) >> 8;
        dc = ((a & 15) + (b & 15) + s) >> 4;
        z = (res == 0);
      end else if (op == 5) begin
        res = a & r;
        z = (res == 0);
      end else begin
        res = r & ~(1 << bi) & 255;
      end
      if (op == 3 || op == 4 || (op != 6 && dst == 0)) a = res;
      else r = res;
      apb(1'b0, OFF_WORK, 0);
      chk("work", a, rd);
      apb(1'b0, {REGION_R, ri[5:0], 2'h0}, 0);
      chk("reg", r, rd);
      apb(1'b0, OFF_STATUS, 0);
      chk("status", 32'h18 | (z << 2) | (dc << 1) | cy, rd);
    end
    $display("test ops done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, pa[i], 0);
      chk("slverr", pe[i], er);
    end
    apb(1'b1, OFF_CMD, 32'h0044_0002);
    apb(1'b0, OFF_STATUS, 0);
    chk("err", 1, rd[5]);
    apb(1'b1, OFF_STATUS, 32'h20);
    apb(1'b1, OFF_CMD, 32'h0085_0002);
    apb(1'b0, OFF_STATUS, 0);
    chk("err", 0, rd[5]);
    apb(1'b1, OFF_CMD, 32'h00C0_0002);
    apb(1'b0, OFF_STATUS, 0);
    chk("err", 1, rd[5]);
    apb(1'b1, OFF_STATUS, 32'h20);
    apb(1'b1, OFF_CMD, 32'h0000_0009);
    apb(1'b0, OFF_STATUS, 0);
    chk("err", 1, rd[5]);
    $display("test pages done");
    flag_step(0, 2'h1);
    flag_step(8, 2'h2);
    flag_step(0, 2'h0);
    flag_step(7, 2'h3);
    flag_step(8, 2'h2);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, OFF_STATUS, 0);
    chk("status", 32'h18, rd);
    chk("flag_pins", 2'h3, {timeout_flag_n, powerdown_flag_n});
    $display("test flags done");
    final_report();
  end
endmodule : tb
bind arith_core arith_core_properties i_props (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wdt_timeout(wdt_timeout),
  .powerdown_flag_n(powerdown_flag_n), .timeout_flag_n(timeout_flag_n));
